// [design/imm_decode_params.svh]
`ifndef IMM_DECODE_PARAMS_SVH
`define IMM_DECODE_PARAMS_SVH

// ==========================================================================
// Opcode field positions and codes
// ==========================================================================
`define OPC_UPPER6_MSB      15
`define OPC_UPPER6_LSB      10
`define OPC_LOAD_LO         6'h00
`define OPC_LOAD_HI         6'h01
`define OPC_STORE           6'h02
`define OPC_BYTE_TOP2       2'h2
`define OPC_SHIFT_TOP4      4'hc
`define OPC_COND_MSB        14
`define OPC_COND_LSB        11
`define COND_ALWAYS         4'hf
`define OFFSET_MSB          3
`define BRANCH_IMM_MSB      4
`define JUMP_IMM_MSB        5
`define BYTE_IMM_MSB        7

`endif

// [design/imm_decode_pkg.sv]
package imm_decode_pkg;

  typedef enum logic [3:0] {
    dec_none,
    mem_load_offset,
    mem_load_offset_upper,
    mem_store_offset,
    mem_store_offset_upper,
    branch_short,
    branch_short_always,
    load_byte_literal,
    shift_by_literal
  } op_class_e;

  typedef struct packed {
    logic        mem_read;
    logic        mem_write;
    logic        write_upper;
    logic        read_upper;
    logic [15:0] mem_addr;
    logic        a_write;
    logic [31:0] a_value;
    logic        pc_load;
    logic [15:0] pc_next;
  } ctrl_s;

endpackage

// [design/immediate_opcode_decoder.sv]
`include "imm_decode_params.svh"

module immediate_opcode_decoder
(
  input  wire logic                 core_clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 instr_valid_i,
  input  wire logic [15:0]          instr_i,
  input  wire logic                 store_upper_i,
  input  wire logic [31:0]          operand_a_i,
  input  wire logic [31:0]          operand_b_i,
  input  wire logic [15:0]          pc_i,
  input  wire logic [15:0]          mem_rdata_i,
  output logic                      ctrl_valid_o,
  output imm_decode_pkg::ctrl_s     ctrl_o,
  output imm_decode_pkg::op_class_e op_class_o,
  output logic [15:0]               mem_wdata_o
);

  // ==========================================================================
  // Decode
  // ==========================================================================
  imm_decode_pkg::op_class_e next_class;
  logic [5:0]                upper6;
  logic [3:0]                cond;
  logic                      cond_true;
  logic [15:0]               offset_addr;

  assign upper6      = instr_i[`OPC_UPPER6_MSB:`OPC_UPPER6_LSB];
  assign cond        = instr_i[`OPC_COND_MSB:`OPC_COND_LSB];
  assign offset_addr = operand_b_i[15:0] + {12'h000, instr_i[`OFFSET_MSB:0]};

  // Condition codes: bit3 selects A-vs-B against A-vs-zero, bits2:0 are gt/lt/eq
  function automatic logic cond_eval(input logic [3:0] c, input logic [31:0] a,
                                     input logic [31:0] b);
    logic gt;
    logic lt;
    logic eq;
    gt = 1'b0;
    lt = 1'b0;
    eq = 1'b0;
    if (c[3])
    begin
      gt = a > b;
      lt = $signed(a) < $signed(b);
      eq = a == b;
    end
    else
    begin
      gt = $signed(a) > 0;
      lt = $signed(a) < 0;
      eq = a == 32'h0000_0000;
    end
    cond_eval = (c[2] & gt) | (c[1] & lt) | (c[0] & eq);
  endfunction

  assign cond_true = cond_eval(cond, operand_a_i, operand_b_i);

  always_comb
  begin
    next_class = imm_decode_pkg::dec_none;
    if (upper6 == `OPC_LOAD_LO)
      next_class = imm_decode_pkg::mem_load_offset;
    else if (upper6 == `OPC_LOAD_HI)
      next_class = imm_decode_pkg::mem_load_offset_upper;
    else if (upper6 == `OPC_STORE)
      // Both stores share one code; the core's extended flag picks the half
      next_class = store_upper_i ? imm_decode_pkg::mem_store_offset_upper
                                 : imm_decode_pkg::mem_store_offset;
    else if (!instr_i[15] && cond == `COND_ALWAYS)
      next_class = imm_decode_pkg::branch_short_always;
    else if (!instr_i[15] && cond[2:0] != 3'h0)
      next_class = imm_decode_pkg::branch_short;
    else if (instr_i[15:14] == `OPC_BYTE_TOP2)
      next_class = imm_decode_pkg::load_byte_literal;
    else if (instr_i[15:12] == `OPC_SHIFT_TOP4)
      next_class = imm_decode_pkg::shift_by_literal;
  end

  // ==========================================================================
  // Control generation
  // ==========================================================================
  imm_decode_pkg::ctrl_s next_ctrl;
  logic signed [5:0]     shamt;
  logic [15:0]           next_wdata;

  assign shamt = $signed(instr_i[`JUMP_IMM_MSB:0]);

  always_comb
  begin
    next_ctrl   = '0;
    next_wdata  = 16'h0000;
    case (next_class)
      imm_decode_pkg::mem_load_offset:
      begin
        next_ctrl.mem_read = 1'b1;
        next_ctrl.mem_addr = offset_addr;
        next_ctrl.a_write  = 1'b1;
        next_ctrl.a_value  = {{16{mem_rdata_i[15]}}, mem_rdata_i};
      end
      imm_decode_pkg::mem_load_offset_upper:
      begin
        next_ctrl.mem_read   = 1'b1;
        next_ctrl.read_upper = 1'b1;
        next_ctrl.mem_addr   = offset_addr;
        next_ctrl.a_write    = 1'b1;
        next_ctrl.a_value    = {mem_rdata_i, operand_a_i[15:0]};
      end
      imm_decode_pkg::mem_store_offset:
      begin
        next_ctrl.mem_write = 1'b1;
        next_ctrl.mem_addr  = offset_addr;
        next_wdata          = operand_a_i[15:0];
      end
      imm_decode_pkg::mem_store_offset_upper:
      begin
        next_ctrl.mem_write   = 1'b1;
        next_ctrl.write_upper = 1'b1;
        next_ctrl.mem_addr    = offset_addr;
        next_wdata            = operand_a_i[31:16];
      end
      imm_decode_pkg::branch_short:
      begin
        next_ctrl.pc_load = cond_true;
        next_ctrl.pc_next = pc_i + {{11{instr_i[`BRANCH_IMM_MSB]}},
                                    instr_i[`BRANCH_IMM_MSB:0]};
      end
      imm_decode_pkg::branch_short_always:
      begin
        next_ctrl.pc_load = 1'b1;
        next_ctrl.pc_next = pc_i + {{10{instr_i[`JUMP_IMM_MSB]}},
                                    instr_i[`JUMP_IMM_MSB:0]};
      end
      imm_decode_pkg::load_byte_literal:
      begin
        next_ctrl.a_write = 1'b1;
        next_ctrl.a_value = {{24{instr_i[`BYTE_IMM_MSB]}},
                             instr_i[`BYTE_IMM_MSB:0]};
      end
      imm_decode_pkg::shift_by_literal:
      begin
        next_ctrl.a_write = 1'b1;
        // Negative amounts shift right, keeping the sign
        if (shamt < 0)
          next_ctrl.a_value = 32'($signed(operand_a_i) >>> (-shamt));
        else
          next_ctrl.a_value = operand_a_i << shamt;
      end
      default:
      begin
        next_ctrl = '0;
      end
    endcase
    if (!instr_valid_i)
    begin
      next_ctrl  = '0;
      next_wdata = 16'h0000;
    end
  end

  // ==========================================================================
  // Output registers
  // ==========================================================================
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      ctrl_o      <= '0;
      mem_wdata_o <= 16'h0000;
    end
    else
    begin
      ctrl_o      <= next_ctrl;
      mem_wdata_o <= next_wdata;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      ctrl_valid_o <= 1'b0;
      op_class_o   <= imm_decode_pkg::dec_none;
    end
    else
    begin
      ctrl_valid_o <= instr_valid_i;
      op_class_o   <= instr_valid_i ? next_class : imm_decode_pkg::dec_none;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  a_load_reads_mem: assert property (@(posedge core_clk_i) disable iff (rst_i)
    instr_valid_i && upper6 == `OPC_LOAD_LO |=> ctrl_o.mem_read && ctrl_o.a_write
      && ctrl_o.mem_addr == $past(offset_addr))
    else $error("load offset not decoded");

  a_upper_load_keeps: assert property (@(posedge core_clk_i) disable iff (rst_i)
    instr_valid_i && upper6 == `OPC_LOAD_HI |=>
      ctrl_o.a_value == {$past(mem_rdata_i), $past(operand_a_i[15:0])})
    else $error("upper load value wrong");

  a_store_low_half: assert property (@(posedge core_clk_i) disable iff (rst_i)
    instr_valid_i && upper6 == `OPC_STORE && !store_upper_i |=>
      ctrl_o.mem_write && mem_wdata_o == $past(operand_a_i[15:0]))
    else $error("low store data wrong");

  a_store_high_half: assert property (@(posedge core_clk_i) disable iff (rst_i)
    instr_valid_i && upper6 == `OPC_STORE && store_upper_i |=>
      ctrl_o.write_upper && mem_wdata_o == $past(operand_a_i[31:16]))
    else $error("high store data wrong");

  a_branch_cond: assert property (@(posedge core_clk_i) disable iff (rst_i)
    instr_valid_i && next_class == imm_decode_pkg::branch_short |=>
      ctrl_o.pc_load == $past(cond_true))
    else $error("branch condition mismatch");

  a_ne_zero_test: assert property (@(posedge core_clk_i) disable iff (rst_i)
    instr_valid_i && !instr_i[15] && cond == 4'h6 && operand_a_i == 32'h0 |=>
      !ctrl_o.pc_load)
    else $error("not-zero test taken on zero");

  a_jump_always: assert property (@(posedge core_clk_i) disable iff (rst_i)
    instr_valid_i && !instr_i[15] && cond == `COND_ALWAYS |=> ctrl_o.pc_load
      && ctrl_o.pc_next == $past(pc_i) + {{10{$past(instr_i[5])}}, $past(instr_i[5:0])})
    else $error("unconditional jump wrong");

  a_byte_literal: assert property (@(posedge core_clk_i) disable iff (rst_i)
    instr_valid_i && instr_i[15:14] == `OPC_BYTE_TOP2 |=>
      ctrl_o.a_write && ctrl_o.a_value[31:7] == {25{$past(instr_i[7])}})
    else $error("byte literal not sign extended");

  a_shift_zero: assert property (@(posedge core_clk_i) disable iff (rst_i)
    instr_valid_i && instr_i[15:12] == `OPC_SHIFT_TOP4 && instr_i[5:0] == 6'h00 |=>
      ctrl_o.a_value == $past(operand_a_i))
    else $error("zero shift altered A");

endmodule

// [verification/tb.sv]
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // Signals and design
  // ==========================================================================
  logic                      core_clk_i;
  logic                      rst_i;
  logic                      instr_valid_i;
  logic [15:0]               instr_i;
  logic                      store_upper_i;
  logic [31:0]               operand_a_i;
  logic [31:0]               operand_b_i;
  logic [15:0]               pc_i;
  logic [15:0]               mem_rdata_i;
  logic                      ctrl_valid_o;
  imm_decode_pkg::ctrl_s     ctrl_o;
  imm_decode_pkg::op_class_e op_class_o;
  logic [15:0]               mem_wdata_o;
  int                        mismatches = 0;
  int                        cmp_count = 0;
  int                        cycles = 0;

  immediate_opcode_decoder i_immediate_opcode_decoder (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .store_upper_i(store_upper_i), .operand_a_i(operand_a_i),
    .operand_b_i(operand_b_i), .pc_i(pc_i), .mem_rdata_i(mem_rdata_i),
    .ctrl_valid_o(ctrl_valid_o), .ctrl_o(ctrl_o), .op_class_o(op_class_o),
    .mem_wdata_o(mem_wdata_o));

  initial
  begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end

  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Ceiling is far above the fewer than a hundred cycles the tests need
  always @(posedge core_clk_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      finish_test();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cls(input imm_decode_pkg::op_class_e e);
    chk("op_class", {28'h0, e}, {28'h0, op_class_o});
  endtask

  // One instruction per call; outputs are settled one edge later
  task automatic issue(input logic [15:0] ins, input logic [31:0] a, input logic [31:0] b,
                       input logic [15:0] rd, input logic su);
    @(posedge core_clk_i);
    #1;
    instr_valid_i = 1'b1;
    instr_i = ins;
    operand_a_i = a;
    operand_b_i = b;
    mem_rdata_i = rd;
    store_upper_i = su;
    @(posedge core_clk_i);
    #1;
    instr_valid_i = 1'b0;
    chk("ctrl_valid", 1, ctrl_valid_o);
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_mem();
    issue(16'h000f, 32'h0, 32'h0000fff8, 16'h8001, 1'b0);
    cls(imm_decode_pkg::mem_load_offset);
    chk("load_addr", 16'h0007, ctrl_o.mem_addr);
    chk("load_value", 32'hffff8001, ctrl_o.a_value);
    chk("load_rd", 1, ctrl_o.mem_read & ctrl_o.a_write);
    chk("load_lo_half", 0, ctrl_o.read_upper);
    issue(16'h0403, 32'h12345678, 32'h20, 16'habcd, 1'b0);
    cls(imm_decode_pkg::mem_load_offset_upper);
    chk("upper_addr", 16'h0023, ctrl_o.mem_addr);
    chk("upper_value", 32'habcd5678, ctrl_o.a_value);
    chk("upper_rd", 1, ctrl_o.read_upper);
    for (int u = 0; u < 2; u++)
    begin
      issue(16'h0805, 32'hcafe1234, 32'h100, 16'h0, u[0]);
      chk("store_wr", 1, ctrl_o.mem_write);
      chk("store_addr", 16'h0105, ctrl_o.mem_addr);
      chk("store_data", u ? 16'hcafe : 16'h1234, mem_wdata_o);
      chk("store_upper", u, ctrl_o.write_upper);
    end
    $display("test mem done");
  endtask

  task automatic t_branch();
    logic [31:0] a;
    logic [31:0] b;
    logic        gt;
    logic        lt;
    logic        eq;
    logic        met;
    for (int s = 0; s < 2; s++)
      for (int c = 1; c < 15; c++)
        if (c[2:0] != 3'h0)
        begin
          a = s ? 32'hfffffff0 : 32'h5;
          b = s ? 32'h10 : 32'h5;
          gt = c[3] ? a > b : $signed(a) > 0;
          lt = c[3] ? $signed(a) < $signed(b) : $signed(a) < 0;
          eq = c[3] ? a == b : a == 0;
          met = (c[2] && gt) || (c[1] && lt) || (c[0] && eq);
          issue({1'b0, c[3:0], 1'b1, 5'h00, 5'h10}, a, b, 16'h0, 1'b0);
          cls(imm_decode_pkg::branch_short);
          chk("branch_taken", met, ctrl_o.pc_load);
          if (met)
            chk("branch_target", 16'h00f0, ctrl_o.pc_next);
        end
    issue({1'b0, 4'hf, 5'h00, 6'h20}, 32'h0, 32'h1, 16'h0, 1'b0);
    cls(imm_decode_pkg::branch_short_always);
    chk("jump_taken", 1, ctrl_o.pc_load);
    chk("jump_target", 16'h00e0, ctrl_o.pc_next);
    issue({1'b0, 4'h6, 1'b1, 5'h00, 5'h01}, 32'h0, 32'h0, 16'h0, 1'b0);
    chk("ne_zero", 0, ctrl_o.pc_load);
    issue({1'b0, 4'hc, 1'b1, 5'h00, 5'h0f}, 32'hfffffff0, 32'h10, 16'h0, 1'b0);
    chk("ugt_taken", 1, ctrl_o.pc_load);
    chk("fwd_target", 16'h010f, ctrl_o.pc_next);
    $display("test branch done");
  endtask

  task automatic t_alu();
    issue({2'b10, 6'h00, 8'h80}, 32'h0, 32'h0, 16'h0, 1'b0);
    cls(imm_decode_pkg::load_byte_literal);
    chk("byte_neg", 32'hffffff80, ctrl_o.a_value);
    issue({2'b10, 6'h00, 8'h7f}, 32'h0, 32'h0, 16'h0, 1'b0);
    chk("byte_pos", 32'h0000007f, ctrl_o.a_value);
    issue({4'hc, 6'h00, 6'h1f}, 32'h1, 32'h0, 16'h0, 1'b0);
    cls(imm_decode_pkg::shift_by_literal);
    chk("shift_left", 32'h80000000, ctrl_o.a_value);
    chk("shift_wr", 1, ctrl_o.a_write);
    issue({4'hc, 6'h00, 6'h3f}, 32'h80000000, 32'h0, 16'h0, 1'b0);
    chk("shift_right", 32'hc0000000, ctrl_o.a_value);
    issue({4'hc, 6'h00, 6'h00}, 32'h89abcdef, 32'h0, 16'h0, 1'b0);
    chk("shift_none", 32'h89abcdef, ctrl_o.a_value);
    $display("test alu done");
  endtask

  task automatic t_idle();
    issue(16'hd000, 32'h1, 32'h1, 16'h0, 1'b0);
    cls(imm_decode_pkg::dec_none);
    chk("unmatched_zero", 1, ctrl_o === '0);
    @(posedge core_clk_i);
    #1;
    chk("idle_valid", 0, ctrl_valid_o);
    cls(imm_decode_pkg::dec_none);
    // Reset in mid-run must win over a valid instruction
    @(posedge core_clk_i);
    #1;
    rst_i = 1'b1;
    instr_valid_i = 1'b1;
    instr_i = 16'h000f;
    @(posedge core_clk_i);
    #1;
    rst_i = 1'b0;
    instr_valid_i = 1'b0;
    chk("rst_valid", 0, ctrl_valid_o);
    chk("rst_ctrl", 1, ctrl_o === '0);
    cls(imm_decode_pkg::dec_none);
    $display("test idle done");
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    rst_i = 1'b1;
    instr_valid_i = 1'b0;
    instr_i = 16'h0;
    store_upper_i = 1'b0;
    operand_a_i = 32'h0;
    operand_b_i = 32'h0;
    pc_i = 16'h0100;
    mem_rdata_i = 16'h0;
    repeat (2) @(posedge core_clk_i);
    #1;
    rst_i = 1'b0;
    chk("reset_valid", 0, ctrl_valid_o);
    chk("reset_ctrl", 1, ctrl_o === '0);
    t_mem();
    t_branch();
    t_alu();
    t_idle();
    finish_test();
  end
endmodule
